// ==== logic/csp_pkg.sv ====
// Constants, register map and carrier types for the clock select block.
// Assumes a single 100 MHz ref_clk domain and a plain register port.
//
// Summary of operation
// - Switch system clock among three sources without glitches or runt pulses.
// - Reference clock is the selected source straight out of reset.
// - Three separate dividers make core, fast bus and peripheral clocks.
// - Alternate clock from a general-purpose pin is the third source.
// - Out-of-lock warm reset forces reference source until software clears it.
// - Override sticky flag shows the forced fallback; clearing it frees selector.
// - Each synthesiser stage has its own reset and bypass control.
// - Stage one output feeds stage two; same limits for both stages; no feed while stage one is bypassed.
// - Stage divides input, multiplies by ratio, divides output; filter range.
// - Lock detect enable and mode exist; enable only after lock (the enable bit acts as written, whatever the raw lock state).
// - Count measurements whose output/input ratio is below min or above max.
// - Out-of-lock when exception count exceeds underflow or overflow limit.
// - Out-of-lock shows in both lock event flag and unlock status.
// - Warm reset on out-of-lock only when the reset mask permits.
// - Raw lock status bit shows the synthesiser's current lock state.
// - Write-one-to-clear bits clear on one, ignore zero.
package csp_pkg;
  localparam logic [7:0] CSP_STATUS_OFS = 8'h04;
  localparam logic [7:0] CSP_CLKSEL_OFS = 8'h10;
  localparam logic [7:0] CSP_DIV_OFS = 8'h14;
  localparam logic [7:0] CSP_SYN1_OFS = 8'h18;
  localparam logic [7:0] CSP_LOCK_OFS = 8'h1C;
  localparam logic [7:0] CSP_SYN2_OFS = 8'h20;
  localparam logic [31:0] CSP_CLKSEL_RST = 32'h0000_0000;
  localparam logic [31:0] CSP_DIV_RST = 32'h0000_0000;
  localparam logic [31:0] CSP_SYN_RST = 32'h0000_0003;
  localparam logic [31:0] CSP_LOCK_RST = 32'h0000_0000;
  localparam int CSP_ST_RAW = 0;
  localparam int CSP_ST_EVENT = 1;
  localparam int CSP_ST_UNLOCK = 2;
  localparam int CSP_ST_OVR = 3;
  localparam int CSP_ST_ACT_LSB = 4;
  localparam int CSP_CS_SEL_LSB = 0;
  localparam int CSP_CS_MASK = 4;
  localparam int CSP_DIV_W = 8;
  localparam int CSP_SY_RST = 0;
  localparam int CSP_SY_BYP = 1;
  localparam int CSP_SY_FR_LSB = 4;
  localparam int CSP_SY_IN_LSB = 8;
  localparam int CSP_SY_RAT_LSB = 16;
  localparam int CSP_SY_OUT_LSB = 24;
  localparam int CSP_LK_EN = 0;
  localparam int CSP_LK_MODE = 1;
  localparam int CSP_LK_MIN_LSB = 8;
  localparam int CSP_LK_MAX_LSB = 16;
  localparam int CSP_LK_UND_LSB = 24;
  localparam int CSP_LK_OVF_LSB = 28;
  localparam int CSP_WINDOW_CYCLES = 256;

  typedef enum logic [1:0] {
    CSP_SRC_REF = 2'h0,
    CSP_SRC_SYNTH = 2'h1,
    CSP_SRC_ALT = 2'h2
  } csp_src_e;

  typedef enum logic [2:0] {
    CSP_SW_IDLE = 3'h1,
    CSP_SW_DROP = 3'h2,
    CSP_SW_RAISE = 3'h4
  } csp_sw_e;

  typedef struct packed {
    logic [5:0] out_div;
    logic [7:0] ratio;
    logic [3:0] in_div;
    logic [1:0] frange;
    logic bypass;
    logic reset;
  } csp_stage_s;

  typedef struct packed {
    logic [3:0] ovf_lim;
    logic [3:0] und_lim;
    logic [7:0] max;
    logic [7:0] min;
    logic mode;
    logic enable;
  } csp_lock_s;
endpackage : csp_pkg

// ==== logic/csp_lock_det.sv ====
// Ratio based out-of-lock detector for the two-stage synthesiser.
// Assumes fb_edge is a one-cycle pulse per rising edge of the stage two
// feedback tap, already synchronised to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module csp_lock_det
  import csp_pkg::*;
#(
  parameter int WINDOW_CYCLES = CSP_WINDOW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire csp_lock_s cfg,
  input wire logic fb_edge,
  output logic out_of_lock
);
  localparam int WW = $clog2(WINDOW_CYCLES);

  if (WINDOW_CYCLES < 2 || WINDOW_CYCLES > 65536) begin : g_chk
    $error("WINDOW_CYCLES must lie in 2..65536");
  end

  logic [WW-1:0] win_reg;
  logic [7:0] edge_reg;
  logic [4:0] und_reg;
  logic [4:0] ovf_reg;
  logic lost_reg;

  // Counts clear and hold at zero while detection is off, so stale counts never fire.
  wire clr = rst | ~cfg.enable;
  wire win_end = win_reg == WW'(WINDOW_CYCLES - 1);
  wire too_low = edge_reg < cfg.min;
  wire too_high = edge_reg > cfg.max;
  wire good = ~too_low & ~too_high;
  // Mode one wants consecutive exceptions; a good window restarts counts.
  wire restart = win_end & good & cfg.mode;
  wire [7:0] edge_inc = (edge_reg == 8'hFF) ? edge_reg : edge_reg + 8'h01;
  wire [4:0] und_inc = (und_reg == 5'h1F) ? und_reg : und_reg + 5'h01;
  wire [4:0] ovf_inc = (ovf_reg == 5'h1F) ? ovf_reg : ovf_reg + 5'h01;
  wire exceeded = (und_reg > {1'b0, cfg.und_lim})
                | (ovf_reg > {1'b0, cfg.ovf_lim});

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      win_reg <= '0;
      edge_reg <= 8'h00;
      und_reg <= 5'h00;
      ovf_reg <= 5'h00;
      lost_reg <= 1'b0;
    end else begin
      win_reg <= win_end ? '0 : win_reg + WW'(1);
      if (win_end) begin
        edge_reg <= {7'h00, fb_edge};
      end else if (fb_edge) begin
        edge_reg <= edge_inc;
      end
      if (restart) begin
        und_reg <= 5'h00;
        ovf_reg <= 5'h00;
      end else if (win_end) begin
        und_reg <= too_low ? und_inc : und_reg;
        ovf_reg <= too_high ? ovf_inc : ovf_reg;
      end
      lost_reg <= lost_reg | exceeded;
    end
  end

  assign out_of_lock = lost_reg;
endmodule : csp_lock_det
`default_nettype wire

// ==== logic/csp_clock_ctrl.sv ====
// Clock source selector, system clock dividers, synthesiser control and
// lock supervision, with a small register port.
// Assumes the synthesiser, feedback and alternate clocks arrive as pins sampled by the faster ref_clk;
// the reference source is modelled as ref_clk divided by two.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module csp_clock_ctrl
  import csp_pkg::*;
#(
  parameter int WINDOW_CYCLES = CSP_WINDOW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic synth_output_clock,
  input wire logic synth_fb_clock,
  input wire logic alternate_gpio_clock,
  input wire logic synth_lock_raw,
  output logic sys_clock,
  output logic core_dsp_clock,
  output logic fast_bus_clock,
  output logic peripheral_bus_clock,
  output csp_stage_s stage1_cfg,
  output csp_stage_s stage2_cfg,
  output logic stage2_from_stage1,
  output logic warm_reset
);
  // Pin inputs: synth clock, feedback tap, alternate clock, raw lock.
  localparam int NPIN = 4;

  // The detector needs a window of at least two cycles to see an end, and
  // its window counter is kept to sixteen bits to stay small.
  if (WINDOW_CYCLES < 2 || WINDOW_CYCLES > 65536) begin : g_win_chk
    $error("WINDOW_CYCLES must lie in 2..65536");
  end

  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] pin_flt;
  logic [31:0] clksel_reg;
  logic [31:0] div_reg;
  logic [31:0] syn1_reg;
  logic [31:0] syn2_reg;
  logic [31:0] lock_reg;
  logic event_reg;
  logic override_reg;
  logic lost_prev_reg;
  logic warm_reset_reg;
  logic ref_lvl_reg;
  logic fb_prev_reg;
  logic sys_lvl_reg;
  logic sys_prev_reg;
  logic [31:0] rdata_reg;
  csp_sw_e sw_reg;
  csp_sw_e sw_next;
  csp_src_e active_reg;
  csp_src_e target_reg;
  csp_src_e target_next;
  csp_src_e active_next;
  logic [2:0] en_req_reg;
  logic [2:0] en_req_next;
  logic [2:0] en_act;
  logic [2:0] src_lvl;
  logic [2:0] div_clk;
  logic out_of_lock;

  assign pin_in = {synth_lock_raw, alternate_gpio_clock, synth_fb_clock,
                   synth_output_clock};

  // Three-stage sampling; a new level is taken once stages two and three
  // agree, which rejects a single metastable or noisy sample.
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic flt_reg;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        flt_reg <= 1'b0;
      end else begin
        s1_reg <= pin_in[p];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          flt_reg <= s3_reg;
        end
      end
    end
    assign pin_flt[p] = flt_reg;
  end

  wire synth_lvl = pin_flt[0];
  wire fb_lvl = pin_flt[1];
  wire alt_lvl = pin_flt[2];
  wire raw_lock = pin_flt[3];

  // Register decode.
  wire hit_status = reg_addr == CSP_STATUS_OFS;
  wire hit_clksel = reg_addr == CSP_CLKSEL_OFS;
  wire hit_div = reg_addr == CSP_DIV_OFS;
  wire hit_syn1 = reg_addr == CSP_SYN1_OFS;
  wire hit_lock = reg_addr == CSP_LOCK_OFS;
  wire hit_syn2 = reg_addr == CSP_SYN2_OFS;
  wire wr_status = reg_wr & hit_status;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clksel_reg <= CSP_CLKSEL_RST;
      div_reg <= CSP_DIV_RST;
      syn1_reg <= CSP_SYN_RST;
      syn2_reg <= CSP_SYN_RST;
      lock_reg <= CSP_LOCK_RST;
    end else if (reg_wr) begin
      if (hit_clksel) clksel_reg <= reg_wdata;
      if (hit_div) div_reg <= reg_wdata;
      if (hit_syn1) syn1_reg <= reg_wdata;
      if (hit_syn2) syn2_reg <= reg_wdata;
      if (hit_lock) lock_reg <= reg_wdata;
    end
  end

  // Synthesiser stage fields go straight to the analog macro; a reset or
  // bypass bit acts on its own stage; stage one's bypass also drives stage2_from_stage1.
  function automatic csp_stage_s stage_of(input logic [31:0] r);
    csp_stage_s s;
    s.reset = r[CSP_SY_RST];
    s.bypass = r[CSP_SY_BYP];
    s.frange = r[CSP_SY_FR_LSB +: 2];
    s.in_div = r[CSP_SY_IN_LSB +: 4];
    s.ratio = r[CSP_SY_RAT_LSB +: 8];
    s.out_div = r[CSP_SY_OUT_LSB +: 6];
    return s;
  endfunction : stage_of

  assign stage1_cfg = stage_of(syn1_reg);
  assign stage2_cfg = stage_of(syn2_reg);
  // Stage two runs from stage one's output unless stage one is bypassed.
  assign stage2_from_stage1 = ~syn1_reg[CSP_SY_BYP];

  csp_lock_s lock_cfg;
  assign lock_cfg.enable = lock_reg[CSP_LK_EN];
  assign lock_cfg.mode = lock_reg[CSP_LK_MODE];
  assign lock_cfg.min = lock_reg[CSP_LK_MIN_LSB +: 8];
  assign lock_cfg.max = lock_reg[CSP_LK_MAX_LSB +: 8];
  assign lock_cfg.und_lim = lock_reg[CSP_LK_UND_LSB +: 4];
  assign lock_cfg.ovf_lim = lock_reg[CSP_LK_OVF_LSB +: 4];

  // The feedback tap is the stage two output, measured against ref_clk,
  // which is the stage one input.
  wire fb_edge = fb_lvl & ~fb_prev_reg;

  csp_lock_det #(
    .WINDOW_CYCLES(WINDOW_CYCLES)
  ) u_lock_det (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg(lock_cfg),
    .fb_edge(fb_edge),
    .out_of_lock(out_of_lock)
  );

  // Only the rising edge of the lost condition acts, so one loss of lock
  // gives one warm reset pulse however long the detector stays tripped.
  wire lost_rise = out_of_lock & ~lost_prev_reg;
  wire reset_ok = clksel_reg[CSP_CS_MASK];
  wire warm_cause = lost_rise & reset_ok;
  wire clr_event = wr_status & reg_wdata[CSP_ST_EVENT];
  wire clr_ovr = wr_status & reg_wdata[CSP_ST_OVR];

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_reg <= 1'b0;
      override_reg <= 1'b0;
      lost_prev_reg <= 1'b0;
      warm_reset_reg <= 1'b0;
    end else begin
      lost_prev_reg <= out_of_lock;
      warm_reset_reg <= warm_cause;
      event_reg <= lost_rise | (event_reg & ~clr_event);
      override_reg <= warm_cause | (override_reg & ~clr_ovr);
    end
  end

  assign warm_reset = warm_reset_reg;

  // Source choice: the override pins the reference until it is cleared;
  // the unused code 3 also means the reference.
  wire [1:0] sel_field = clksel_reg[CSP_CS_SEL_LSB +: 2];
  wire sel_bad = sel_field == 2'h3;
  wire [1:0] want_code = (override_reg | sel_bad) ? CSP_SRC_REF
                                                  : sel_field;
  wire csp_src_e want = csp_src_e'(want_code);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_lvl_reg <= 1'b0;
      fb_prev_reg <= 1'b0;
    end else begin
      ref_lvl_reg <= ~ref_lvl_reg;
      fb_prev_reg <= fb_lvl;
    end
  end

  assign src_lvl = {alt_lvl, synth_lvl, ref_lvl_reg};

  // Each enable only moves while its own source is low, so a source is
  // never cut or started inside a high phase.
  for (genvar s = 0; s < 3; s++) begin : g_src
    logic act_reg;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        act_reg <= (s == 0);
      end else if (!src_lvl[s]) begin
        act_reg <= en_req_reg[s];
      end
    end
    assign en_act[s] = act_reg;
  end

  // Break before make: old enable must be seen off before the new one is
  // requested. A target clock stopped high leaves the switch waiting in RAISE.
  always_comb begin
    sw_next = sw_reg;
    target_next = target_reg;
    active_next = active_reg;
    en_req_next = en_req_reg;
    case (sw_reg)
      CSP_SW_IDLE: begin
        if (want != active_reg) begin
          target_next = want;
          en_req_next[active_reg] = 1'b0;
          sw_next = CSP_SW_DROP;
        end
      end
      CSP_SW_DROP: begin
        if (!en_act[active_reg]) begin
          en_req_next[target_reg] = 1'b1;
          sw_next = CSP_SW_RAISE;
        end
      end
      CSP_SW_RAISE: begin
        if (en_act[target_reg]) begin
          active_next = target_reg;
          sw_next = CSP_SW_IDLE;
        end
      end
      default: begin
        sw_next = CSP_SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_reg <= CSP_SW_IDLE;
      active_reg <= CSP_SRC_REF;
      target_reg <= CSP_SRC_REF;
      en_req_reg <= 3'h1;
    end else begin
      sw_reg <= sw_next;
      active_reg <= active_next;
      target_reg <= target_next;
      en_req_reg <= en_req_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sys_lvl_reg <= 1'b0;
      sys_prev_reg <= 1'b0;
    end else begin
      sys_lvl_reg <= |(src_lvl & en_act);
      sys_prev_reg <= sys_lvl_reg;
    end
  end

  assign sys_clock = sys_lvl_reg;
  wire sys_rise = sys_lvl_reg & ~sys_prev_reg;

  // Divider value 0 passes the system clock; N toggles every N rising
  // edges, giving a divide by 2N with a 50 percent duty cycle.
  for (genvar d = 0; d < 3; d++) begin : g_div
    logic [CSP_DIV_W-1:0] cnt_reg;
    logic clk_reg;
    wire [CSP_DIV_W-1:0] dv = div_reg[d*CSP_DIV_W +: CSP_DIV_W];
    wire at_end = cnt_reg >= dv - 8'h01;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        cnt_reg <= 8'h00;
        clk_reg <= 1'b0;
      end else if (dv == 8'h00) begin
        cnt_reg <= 8'h00;
        clk_reg <= sys_lvl_reg;
      end else if (sys_rise) begin
        cnt_reg <= at_end ? 8'h00 : cnt_reg + 8'h01;
        clk_reg <= at_end ? ~clk_reg : clk_reg;
      end
    end
    assign div_clk[d] = clk_reg;
  end

  assign core_dsp_clock = div_clk[0];
  assign fast_bus_clock = div_clk[1];
  assign peripheral_bus_clock = div_clk[2];

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[CSP_ST_RAW] = raw_lock;
    status_word[CSP_ST_EVENT] = event_reg;
    status_word[CSP_ST_UNLOCK] = out_of_lock;
    status_word[CSP_ST_OVR] = override_reg;
    status_word[CSP_ST_ACT_LSB +: 2] = active_reg;
  end

  wire [31:0] rd_mux = hit_status ? status_word
                     : hit_clksel ? clksel_reg
                     : hit_div ? div_reg
                     : hit_syn1 ? syn1_reg
                     : hit_lock ? lock_reg
                     : hit_syn2 ? syn2_reg
                     : 32'h0000_0000;

  // Read data stands one cycle only; zero otherwise.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule : csp_clock_ctrl
`default_nettype wire

// ==== tb/csp_src_model.sv ====
// Far-side clock sources: synthesiser output, feedback tap, alternate pin.
// Assumes ref_clk at 100 MHz and a synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module csp_src_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fb_stop,
  output logic synth_output_clock,
  output logic synth_fb_clock,
  output logic alternate_gpio_clock,
  output logic synth_lock_raw
);
  logic [4:0] cnt_reg;
  logic [5:0] lk_reg;
  always_ff @(posedge ref_clk) begin
    cnt_reg <= rst ? 5'h00 : cnt_reg + 5'h01;
    lk_reg <= rst ? 6'h00 : (lk_reg[5] ? lk_reg : lk_reg + 6'h01);
  end
  assign synth_output_clock = cnt_reg[2];
  // A stalled tap stands still low, as a dead oscillator would.
  assign synth_fb_clock = cnt_reg[2] & ~fb_stop;
  assign alternate_gpio_clock = cnt_reg[4];
  // Lock is reported only once the loop has had time to settle.
  assign synth_lock_raw = lk_reg[5];
endmodule : csp_src_model
`default_nettype wire

// ==== tb/csp_clock_ctrl_props.sv ====
// Port checker for the clock select block, bound to every instance.
// Assumes one ref_clk domain with synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module csp_clock_ctrl_props
  import csp_pkg::*;
#(
  parameter int WINDOW_CYCLES = CSP_WINDOW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic sys_clock,
  input wire logic core_dsp_clock,
  input wire logic fast_bus_clock,
  input wire logic peripheral_bus_clock,
  input wire csp_stage_s stage1_cfg,
  input wire csp_stage_s stage2_cfg,
  input wire logic stage2_from_stage1,
  input wire logic warm_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Register fields repacked into the stage carrier layout.
  csp_stage_s syn_q;
  always_ff @(posedge ref_clk)
    syn_q <= {reg_wdata[29:16], reg_wdata[11:8], reg_wdata[5:4],
              reg_wdata[1:0]};

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_warm_pulse;
    warm_reset |=> !warm_reset;
  endproperty
  a_warm_pulse: assert property (p_warm_pulse)
    else $error("warm reset longer than one cycle");
  property p_link;
    stage2_from_stage1 == !stage1_cfg.bypass;
  endproperty
  a_link: assert property (p_link)
    else $error("stage chaining wrong");
  property p_rst_out;
    $fell(rst) |-> !sys_clock && !warm_reset && !core_dsp_clock &&
      !fast_bus_clock && !peripheral_bus_clock;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("clock outputs not idle after reset");
  property p_rst_cfg;
    $fell(rst) |-> stage1_cfg.reset && stage1_cfg.bypass &&
      stage2_cfg.reset && stage2_cfg.bypass;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("stages not held after reset");
  property p_ref_start;
    $fell(rst) |-> ##[1:4] sys_clock;
  endproperty
  a_ref_start: assert property (p_ref_start)
    else $error("reference source not running");
  property p_cfg_hold;
    !reg_wr |=> $stable(stage1_cfg) && $stable(stage2_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("stage config changed without write");
  property p_syn1_wr;
    reg_wr && reg_addr == CSP_SYN1_OFS |=> stage1_cfg == syn_q;
  endproperty
  a_syn1_wr: assert property (p_syn1_wr)
    else $error("stage one config wrong");
  property p_syn2_wr;
    reg_wr && reg_addr == CSP_SYN2_OFS |=> stage2_cfg == syn_q;
  endproperty
  a_syn2_wr: assert property (p_syn2_wr)
    else $error("stage two config wrong");
endmodule : csp_clock_ctrl_props
bind csp_clock_ctrl csp_clock_ctrl_props #(.WINDOW_CYCLES(WINDOW_CYCLES))
  u_props (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .sys_clock, .core_dsp_clock, .fast_bus_clock,
  .peripheral_bus_clock, .stage1_cfg, .stage2_cfg, .stage2_from_stage1,
  .warm_reset);
`default_nettype wire

// ==== tb/csp_clock_ctrl_bench.sv ====
// Self-checking bench for the clock select block and its source model.
// Assumes a 16-cycle lock window so that unlock scenarios stay short.
`timescale 1ns/1ns
`default_nettype none
module csp_clock_ctrl_bench
  import csp_pkg::*;
;
  typedef struct {
    logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;
  } csp_row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fb_stop = 1'b0;
  logic [31:0] reg_rdata, d;
  logic so_clk, fb_clk, alt_clk, lock_raw, sys_clock, warm_reset;
  logic core_dsp_clock, fast_bus_clock, peripheral_bus_clock, chain;
  csp_stage_s s1, s2;
  int failures = 0;
  int compares = 0;
  csp_row_s rows[11] = '{
    '{CSP_CLKSEL_OFS, 1'b0, 32'h0, CSP_CLKSEL_RST},
    '{CSP_DIV_OFS, 1'b0, 32'h0, CSP_DIV_RST},
    '{CSP_SYN1_OFS, 1'b0, 32'h0, CSP_SYN_RST},
    '{CSP_SYN2_OFS, 1'b0, 32'h0, CSP_SYN_RST},
    '{CSP_LOCK_OFS, 1'b0, 32'h0, CSP_LOCK_RST},
    '{8'h08, 1'b0, 32'h0, 32'h0},
    '{CSP_SYN1_OFS, 1'b1, 32'h0000_0002, 32'h0000_0002},
    '{CSP_SYN2_OFS, 1'b1, 32'h0153_0010, 32'h0153_0010},
    '{CSP_DIV_OFS, 1'b1, 32'h0002_0100, 32'h0002_0100},
    '{8'h08, 1'b1, 32'hFFFF_FFFF, 32'h0},
    '{CSP_LOCK_OFS, 1'b1, 32'h1112_0100, 32'h1112_0100}};

  always #5 ref_clk = ~ref_clk;

  csp_src_model src (.ref_clk(ref_clk), .rst(rst), .fb_stop(fb_stop),
    .synth_output_clock(so_clk), .synth_fb_clock(fb_clk),
    .alternate_gpio_clock(alt_clk), .synth_lock_raw(lock_raw));

  csp_clock_ctrl #(.WINDOW_CYCLES(16)) uut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .synth_output_clock(so_clk),
    .synth_fb_clock(fb_clk), .alternate_gpio_clock(alt_clk),
    .synth_lock_raw(lock_raw), .sys_clock(sys_clock),
    .core_dsp_clock(core_dsp_clock), .fast_bus_clock(fast_bus_clock),
    .peripheral_bus_clock(peripheral_bus_clock), .stage1_cfg(s1),
    .stage2_cfg(s2), .stage2_from_stage1(chain), .warm_reset(warm_reset));

  task automatic final_report;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Each transfer leaves one idle cycle so no strobe is driven twice.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask : rd

  task automatic wait_sts(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] s;
    for (int n = 0; n < 100; n++) begin
      rd(CSP_STATUS_OFS, s);
      if ((s & m) === v) return;
    end
    chk(s & m, v);
    final_report();
  endtask : wait_sts

  task automatic div_check;
    int ns, nc, nf, np;
    logic [3:0] p, c;
    ns = 0; nc = 0; nf = 0; np = 0; p = 4'h0;
    repeat (96) begin
      @(posedge ref_clk);
      #1 c = {sys_clock, core_dsp_clock, fast_bus_clock,
              peripheral_bus_clock};
      ns += int'(c[3] & ~p[3]);
      nc += int'(c[2] & ~p[2]);
      nf += int'(c[1] & ~p[1]);
      np += int'(c[0] & ~p[0]);
      p = c;
    end
    @(posedge ref_clk);
    chk(32'(ns > 8), 32'h1);
    chk(32'(nc >= ns - 1 && nc <= ns + 1), 32'h1);
    chk(32'(2 * nf >= ns - 2 && 2 * nf <= ns + 2), 32'h1);
    chk(32'(4 * np >= ns - 4 && 4 * np <= ns + 4), 32'h1);
    $display("dividers done");
  endtask : div_check

  task automatic run_unlock(input logic msk);
    int n;
    n = 0;
    wr(CSP_CLKSEL_OFS, {27'h0, msk, 4'h1});
    // Mode one only differs once a window is good again; with the tap
    // stalled every window is bad, so both modes must still trip.
    wr(CSP_LOCK_OFS, 32'h1112_0101 | {30'h0, ~msk, 1'b0});
    fb_stop <= 1'b1;
    while (warm_reset !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    @(posedge ref_clk);
    chk(32'(n < 300), {31'h0, msk});
    if (msk && n >= 300) final_report();
    if (msk) begin
      wait_sts(32'h3E, 32'h0E);
      wr(CSP_STATUS_OFS, 32'h0);
      wr(CSP_CLKSEL_OFS, 32'h11);
      rd(CSP_STATUS_OFS, d);
      chk(d & 32'h3E, 32'h0E);
      wr(CSP_STATUS_OFS, 32'h8);
    end
    wait_sts(32'h3E, 32'h16);
    wr(CSP_STATUS_OFS, 32'h2);
    rd(CSP_STATUS_OFS, d);
    chk(d & 32'h6, 32'h4);
    wr(CSP_LOCK_OFS, 32'h1112_0100);
    fb_stop <= 1'b0;
    rd(CSP_STATUS_OFS, d);
    chk(d & 32'h4, 32'h0);
    $display("unlock done, mask=%0d", msk);
  endtask : run_unlock

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    chk({30'h0, s1.bypass, s1.reset}, 32'h2);
    chk({31'h0, chain}, 32'h0);
    chk({24'h0, s2.ratio}, 32'h53);
    chk({26'h0, s2.out_div}, 32'h01);
    chk({30'h0, s2.frange}, 32'h1);
    $display("table done");
    wr(CSP_CLKSEL_OFS, 32'h2);
    wait_sts(32'h30, 32'h20);
    wait_sts(32'h1, 32'h1);
    wr(CSP_CLKSEL_OFS, 32'h3);
    wait_sts(32'h30, 32'h00);
    wr(CSP_CLKSEL_OFS, 32'h1);
    wait_sts(32'h30, 32'h10);
    $display("select done");
    div_check();
    run_unlock(1'b1);
    run_unlock(1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(CSP_CLKSEL_OFS, d);
    chk(d, CSP_CLKSEL_RST);
    wait_sts(32'h30, 32'h00);
    $display("second reset done");
    final_report();
  end
endmodule : csp_clock_ctrl_bench
`default_nettype wire
